// *** logic/rffc_top.sv ***
// Automatic receive FIFO flow controller with its APB register slave.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module rffc_top import rffc_pkg::*; #(
	parameter int CYC_PER_US = CYC_PER_US_DEF,
	parameter int EXTRA_10M_CYC = JAM_10M_EXTRA_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire rffc_apb_req_t apb_req,
	output rffc_apb_rsp_t apb_rsp,
	input wire logic tx_enabled,
	input wire logic full_duplex,
	input wire logic speed_100,
	input wire logic [LEVEL_W-1:0] rx_fifo_level,
	input wire rffc_rx_evt_t rx_evt,
	input wire logic [QUANTA_W-1:0] pause_quanta_setting,
	input wire logic pause_sent,
	output logic pause_req,
	output logic [QUANTA_W-1:0] pause_time,
	output logic back_pressure
);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	rffc_state_t st_reg;
	rffc_state_t st_next;
	logic [LEVEL_W-1:0] high_bytes;
	logic [LEVEL_W-1:0] low_bytes;
	logic level_high;
	logic level_low;
	logic any_enable;
	logic hd_match;
	logic hd_trigger;
	logic fd_high_ok;
	logic zero_ok;
	logic setup;
	logic access;
	logic [31:0] cfg_word;
	logic [31:0] status_word;

	// Thresholds in bytes; the field counts 64-byte blocks.
	always_comb begin
		high_bytes = LEVEL_W'({st_reg.cfg.flow_high_level, {LEVEL_SHIFT{1'b0}}});
		low_bytes = LEVEL_W'({st_reg.cfg.flow_low_level, {LEVEL_SHIFT{1'b0}}});
		level_high = rx_fifo_level >= high_bytes;
		level_low = rx_fifo_level < low_bytes;
		any_enable = st_reg.cfg.flow_on_every_frame
			| st_reg.cfg.jam_on_group_frame
			| st_reg.cfg.jam_on_own_address;
	end

	// Frame selection in half duplex. The every-frame bit acts on the preamble,
	// so it does not wait for the address to be decoded.
	always_comb begin
		hd_match = 1'b0;
		if (st_reg.cfg.flow_on_every_frame) begin
			hd_match = rx_evt.frame_start;
		end else if (rx_evt.addr_valid) begin
			hd_match = (st_reg.cfg.jam_on_group_frame & rx_evt.is_multicast)
				| (st_reg.cfg.jam_on_own_address & rx_evt.is_own);
		end
		hd_trigger = tx_enabled & !full_duplex & level_high & hd_match;
		fd_high_ok = tx_enabled & full_duplex & level_high
			& st_reg.cfg.flow_on_every_frame;
		zero_ok = tx_enabled & any_enable & level_low;
	end

	// Register images.
	always_comb begin
		cfg_word = WORD_ZERO;
		cfg_word[HI_LSB +: 8] = st_reg.cfg.flow_high_level;
		cfg_word[LO_LSB +: 8] = st_reg.cfg.flow_low_level;
		cfg_word[DUR_LSB +: 4] = st_reg.cfg.jam_duration;
		cfg_word[GROUP_BIT] = st_reg.cfg.jam_on_group_frame;
		cfg_word[OWN_BIT] = st_reg.cfg.jam_on_own_address;
		cfg_word[ANY_BIT] = st_reg.cfg.flow_on_every_frame;
		status_word = WORD_ZERO;
		status_word[0] = level_high;
		status_word[1] = st_reg.pstate == RFFC_PS_ARMED;
		status_word[2] = st_reg.pause_req;
		status_word[3] = back_pressure;
	end

	assign setup = apb_req.psel & !apb_req.penable;
	assign access = apb_req.psel & apb_req.penable & st_reg.rsp.pready;

	always_comb begin
		st_next = st_reg;
		st_next.jam_start = hd_trigger;
		// Answer one cycle after setup; read data is latched then.
		st_next.rsp.pready = setup;
		if (setup) begin
			st_next.rsp.pslverr = 1'b0;
			if (apb_req.paddr == FLOW_CFG_OFF) begin
				st_next.rsp.prdata = cfg_word;
			end else if (apb_req.paddr == FLOW_STATUS_OFF) begin
				st_next.rsp.prdata = status_word;
			end else begin
				st_next.rsp.prdata = WORD_ZERO;
				st_next.rsp.pslverr = 1'b1;
			end
		end
		if (access && apb_req.pwrite && apb_req.paddr == FLOW_CFG_OFF) begin
			st_next.cfg.flow_high_level = apb_req.pwdata[HI_LSB +: 8];
			st_next.cfg.flow_low_level = apb_req.pwdata[LO_LSB +: 8];
			st_next.cfg.jam_duration = apb_req.pwdata[DUR_LSB +: 4];
			st_next.cfg.jam_on_group_frame = apb_req.pwdata[GROUP_BIT];
			st_next.cfg.jam_on_own_address = apb_req.pwdata[OWN_BIT];
			st_next.cfg.flow_on_every_frame = apb_req.pwdata[ANY_BIT];
		end

		// Pause sequencing. A request that loses the transmitter is withdrawn,
		// and a lost zero pause is retried from the armed state.
		case (st_reg.pstate)
			RFFC_PS_IDLE: begin
				if (fd_high_ok) begin
					st_next.pstate = RFFC_PS_HIGH_REQ;
					st_next.pause_req = 1'b1;
					st_next.pause_time = pause_quanta_setting;
				end
			end
			RFFC_PS_HIGH_REQ: begin
				if (!tx_enabled) begin
					st_next.pstate = RFFC_PS_IDLE;
					st_next.pause_req = 1'b0;
				end else if (pause_sent) begin
					st_next.pstate = RFFC_PS_ARMED;
					st_next.pause_req = 1'b0;
				end
			end
			RFFC_PS_ARMED: begin
				if (zero_ok) begin
					st_next.pstate = RFFC_PS_ZERO_REQ;
					st_next.pause_req = 1'b1;
					st_next.pause_time = '0;
				end
			end
			RFFC_PS_ZERO_REQ: begin
				if (!tx_enabled) begin
					st_next.pstate = RFFC_PS_ARMED;
					st_next.pause_req = 1'b0;
				end else if (pause_sent) begin
					st_next.pstate = RFFC_PS_IDLE;
					st_next.pause_req = 1'b0;
				end
			end
			default: begin
				st_next.pstate = RFFC_PS_IDLE;
				st_next.pause_req = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.cfg.flow_high_level <= HI_RESET;
			st_reg.cfg.flow_low_level <= LO_RESET;
			st_reg.cfg.jam_duration <= DUR_RESET;
			st_reg.cfg.jam_on_group_frame <= 1'b0;
			st_reg.cfg.jam_on_own_address <= 1'b0;
			st_reg.cfg.flow_on_every_frame <= 1'b0;
			st_reg.pstate <= RFFC_PS_IDLE;
			st_reg.pause_req <= 1'b0;
			st_reg.pause_time <= '0;
			st_reg.jam_start <= 1'b0;
			st_reg.rsp <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Besides the read-back image, the duration field only reaches the timer, which full duplex never starts.
	rffc_jam_timer #(
		.CYC_PER_US(CYC_PER_US),
		.EXTRA_10M_CYC(EXTRA_10M_CYC)
	) u_jam_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(st_reg.jam_start),
		.abort(!tx_enabled),
		.jam_duration(st_reg.cfg.jam_duration),
		.speed_100(speed_100),
		.busy(back_pressure)
	);

	assign apb_rsp = st_reg.rsp;
	assign pause_req = st_reg.pause_req;
	assign pause_time = st_reg.pause_time;

	sequence s_high_seen;
		st_reg.pstate == RFFC_PS_IDLE && fd_high_ok;
	endsequence

	sequence s_zero_seen;
		st_reg.pstate == RFFC_PS_ARMED && zero_ok;
	endsequence

	property p_high_pause;
		logic [QUANTA_W-1:0] q;
		(s_high_seen, q = pause_quanta_setting) |=> pause_req && pause_time == q;
	endproperty

	chk_txoff_no_pause: assert property (!tx_enabled |=> !pause_req)
		else $error("pause requested with transmitter disabled");
	chk_txoff_no_jam: assert property (!tx_enabled |=> !back_pressure)
		else $error("back pressure with transmitter disabled");
	chk_high_pause_time: assert property (p_high_pause)
		else $error("high pause missing or wrong pause time");
	chk_high_level_cause: assert property ($rose(pause_req) && pause_time != '0
		|-> $past(rx_fifo_level) >= $past(high_bytes))
		else $error("non-zero pause without reaching the high level");
	chk_single_pause: assert property (st_reg.pstate == RFFC_PS_ARMED
		|=> !pause_req || pause_time == '0)
		else $error("second non-zero pause while armed");
	chk_zero_pause: assert property (s_zero_seen |=> pause_req && pause_time == '0)
		else $error("zero pause not requested below low level");
	chk_zero_needs_arm: assert property ($rose(pause_req) && pause_time == '0
		&& st_reg.pstate != RFFC_PS_HIGH_REQ
		|-> $past(st_reg.pstate) == RFFC_PS_ARMED && $past(any_enable))
		else $error("zero pause without a previous sent pause");
	chk_rearm_idle: assert property (st_reg.pstate == RFFC_PS_ZERO_REQ && tx_enabled
		&& pause_sent |=> st_reg.pstate == RFFC_PS_IDLE && !pause_req)
		else $error("controller did not re-arm after zero pause");
	chk_hd_jam: assert property (hd_trigger ##1 tx_enabled |=> back_pressure)
		else $error("selected frame not jammed");
	chk_fd_no_jam: assert property (full_duplex |=> !st_reg.jam_start)
		else $error("jam started in full duplex");
	chk_group_jam: assert property (tx_enabled && !full_duplex && level_high
		&& rx_evt.addr_valid && rx_evt.is_multicast
		&& !st_reg.cfg.flow_on_every_frame
		&& st_reg.cfg.jam_on_group_frame |=> st_reg.jam_start)
		else $error("multicast frame not jammed");
	chk_own_jam: assert property (tx_enabled && !full_duplex && level_high
		&& rx_evt.addr_valid && rx_evt.is_own
		&& !st_reg.cfg.flow_on_every_frame
		&& st_reg.cfg.jam_on_own_address |=> st_reg.jam_start)
		else $error("own-address frame not jammed");
	chk_any_preamble: assert property (tx_enabled && !full_duplex && level_high
		&& rx_evt.frame_start && st_reg.cfg.flow_on_every_frame
		|=> st_reg.jam_start)
		else $error("every-frame mode missed a preamble");
	chk_apb_answer: assert property (setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
		else $error("APB answer not a single cycle after setup");

	// Bus checks. A write lands only in the access cycle, so a setup alone
	// must leave the configuration untouched.
	sequence s_cfg_write;
		access && apb_req.pwrite && apb_req.paddr == FLOW_CFG_OFF;
	endsequence

	sequence s_status_write;
		access && apb_req.pwrite && apb_req.paddr == FLOW_STATUS_OFF;
	endsequence

	sequence s_bad_setup;
		setup && apb_req.paddr != FLOW_CFG_OFF && apb_req.paddr != FLOW_STATUS_OFF;
	endsequence

	sequence s_high_sent;
		st_reg.pstate == RFFC_PS_HIGH_REQ && tx_enabled && pause_sent;
	endsequence

	chk_cfg_high_write: assert property (s_cfg_write
		|=> st_reg.cfg.flow_high_level == $past(apb_req.pwdata[HI_LSB +: 8]))
		else $error("high level field not written");

	chk_cfg_low_write: assert property (s_cfg_write
		|=> st_reg.cfg.flow_low_level == $past(apb_req.pwdata[LO_LSB +: 8]))
		else $error("low level field not written");

	chk_cfg_dur_write: assert property (s_cfg_write
		|=> st_reg.cfg.jam_duration == $past(apb_req.pwdata[DUR_LSB +: 4]))
		else $error("jam duration field not written");

	chk_cfg_any_write: assert property (s_cfg_write
		|=> st_reg.cfg.flow_on_every_frame == $past(apb_req.pwdata[ANY_BIT]))
		else $error("every-frame bit not written");

	chk_cfg_group_write: assert property (s_cfg_write
		|=> st_reg.cfg.jam_on_group_frame == $past(apb_req.pwdata[GROUP_BIT]))
		else $error("group frame bit not written");

	chk_cfg_own_write: assert property (s_cfg_write
		|=> st_reg.cfg.jam_on_own_address == $past(apb_req.pwdata[OWN_BIT]))
		else $error("own address bit not written");

	chk_setup_no_write: assert property (setup
		|=> $stable(st_reg.cfg))
		else $error("configuration changed in a setup cycle");

	chk_status_ro: assert property (s_status_write
		|=> $stable(st_reg.cfg))
		else $error("status write changed the configuration");

	chk_bad_addr: assert property (s_bad_setup
		|=> apb_rsp.pready && apb_rsp.pslverr && apb_rsp.prdata == WORD_ZERO)
		else $error("unmapped address not refused");

	chk_cfg_read: assert property (setup && apb_req.paddr == FLOW_CFG_OFF
		|=> apb_rsp.prdata == $past(cfg_word) && !apb_rsp.pslverr)
		else $error("configuration read data wrong");

	chk_status_read: assert property (setup && apb_req.paddr == FLOW_STATUS_OFF
		|=> apb_rsp.prdata == $past(status_word) && !apb_rsp.pslverr)
		else $error("status read data wrong");

	// Pause sequencing checks.
	chk_high_sent_arm: assert property (s_high_sent
		|=> st_reg.pstate == RFFC_PS_ARMED && !pause_req)
		else $error("sent high pause did not arm the zero pause");

	chk_high_withdraw: assert property (st_reg.pstate == RFFC_PS_HIGH_REQ && !tx_enabled
		|=> st_reg.pstate == RFFC_PS_IDLE && !pause_req)
		else $error("high pause kept with transmitter disabled");

	chk_zero_withdraw: assert property (st_reg.pstate == RFFC_PS_ZERO_REQ && !tx_enabled
		|=> st_reg.pstate == RFFC_PS_ARMED && !pause_req)
		else $error("zero pause kept with transmitter disabled");

	chk_pause_hold: assert property (pause_req && tx_enabled && !pause_sent
		|=> pause_req && $stable(pause_time))
		else $error("pause request or time changed before it was sent");

	chk_pause_release: assert property (pause_req && pause_sent
		|=> !pause_req)
		else $error("pause request kept after it was sent");

	chk_hd_no_pause: assert property (!full_duplex && st_reg.pstate == RFFC_PS_IDLE
		|=> !pause_req)
		else $error("pause requested in half duplex");

	chk_fd_bits_ignored: assert property (st_reg.pstate == RFFC_PS_IDLE
		&& !st_reg.cfg.flow_on_every_frame |=> !pause_req)
		else $error("pause requested without the every-frame bit");

	chk_zero_below_low: assert property ($rose(pause_req)
		&& st_reg.pstate == RFFC_PS_ZERO_REQ
		|-> $past(rx_fifo_level) < $past(low_bytes))
		else $error("zero pause without falling below the low level");

	// Jam start checks.
	chk_jam_needs_start: assert property (!back_pressure && !st_reg.jam_start
		|=> !back_pressure)
		else $error("back pressure without a selected frame");

	chk_jam_needs_level: assert property (!level_high
		|=> !st_reg.jam_start)
		else $error("jam started below the high level");

	chk_jam_txoff_start: assert property (!tx_enabled
		|=> !st_reg.jam_start)
		else $error("jam started with transmitter disabled");

	chk_any_override: assert property (st_reg.cfg.flow_on_every_frame
		&& !rx_evt.frame_start |=> !st_reg.jam_start)
		else $error("address match jammed in every-frame mode");

	chk_no_event_no_jam: assert property (!rx_evt.frame_start && !rx_evt.addr_valid
		|=> !st_reg.jam_start)
		else $error("jam started without a received frame");

endmodule // rffc_top

// *** pkg/rffc_pkg.sv ***
// Package with register map, field layout, timing and carrier types of the flow controller.
// Contract
// - No pause or jam while transmitter disabled.
// - Trigger when fill reaches high level times 64.
// - One pause frame per high-level crossing.
// - High pause time comes from pause quanta.
// - Half duplex jams matching frames for duration.
// - Zero pause when fill below low level.
// - Zero pause only after non-zero pause sent.
// - Any enable bit allows the zero pause.
// - Jam held for period set by duration field.
// - Duration field unused in full duplex.
// - Group frame bit jams in half duplex.
// - Own address bit jams in half duplex.
// - Every-frame bit acts on any frame, overrides.
// - Duration codes map to table of times.
package rffc_pkg;

	localparam int ADDR_W = 12;
	localparam int LEVEL_W = 14;
	localparam int LEVEL_SHIFT = 6;
	localparam int QUANTA_W = 16;
	localparam logic [ADDR_W-1:0] FLOW_CFG_OFF = 12'h0AC;
	localparam logic [ADDR_W-1:0] FLOW_STATUS_OFF = 12'h0C0;
	localparam int HI_LSB = 16;
	localparam int LO_LSB = 8;
	localparam int DUR_LSB = 4;
	localparam int GROUP_BIT = 3;
	localparam int OWN_BIT = 1;
	localparam int ANY_BIT = 0;
	localparam logic [7:0] HI_RESET = 8'h00;
	localparam logic [7:0] LO_RESET = 8'h00;
	localparam logic [3:0] DUR_RESET = 4'h0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// Clock period and the jam times.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CYC_PER_US_DEF = 1000000 / CLK_PERIOD_PS;
	localparam int JAM_10M_EXTRA_NS = 2200;
	localparam int JAM_10M_EXTRA_CYC_DEF = (JAM_10M_EXTRA_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned JAM_US [16] = '{5, 10, 15, 25, 50, 100, 150, 200,
		250, 300, 350, 400, 450, 500, 550, 600};
	localparam int JAM_CNT_W = 18;

	typedef enum logic [1:0] {
		RFFC_PS_IDLE = 2'b00,
		RFFC_PS_HIGH_REQ = 2'b01,
		RFFC_PS_ARMED = 2'b10,
		RFFC_PS_ZERO_REQ = 2'b11
	} rffc_pause_e_t;

	typedef struct packed {
		logic [7:0] flow_high_level;
		logic [7:0] flow_low_level;
		logic [3:0] jam_duration;
		logic jam_on_group_frame;
		logic jam_on_own_address;
		logic flow_on_every_frame;
	} rffc_cfg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} rffc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rffc_apb_rsp_t;

	typedef struct packed {
		logic frame_start;
		logic addr_valid;
		logic is_multicast;
		logic is_own;
	} rffc_rx_evt_t;

	typedef struct packed {
		rffc_cfg_t cfg;
		rffc_pause_e_t pstate;
		logic pause_req;
		logic [QUANTA_W-1:0] pause_time;
		logic jam_start;
		rffc_apb_rsp_t rsp;
	} rffc_state_t;

	typedef struct packed {
		logic busy;
		logic [JAM_CNT_W-1:0] cnt;
	} rffc_timer_t;

endpackage

// *** logic/rffc_jam_timer.sv ***
// Back-pressure duration timer.
`timescale 1ns/1ps
module rffc_jam_timer import rffc_pkg::*; #(
	parameter int CYC_PER_US = CYC_PER_US_DEF,
	parameter int EXTRA_10M_CYC = JAM_10M_EXTRA_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic abort,
	input wire logic [3:0] jam_duration,
	input wire logic speed_100,
	output logic busy
);

	rffc_timer_t st_reg;
	rffc_timer_t st_next;
	logic [JAM_CNT_W-1:0] load;

	always_comb begin
		load = JAM_CNT_W'(JAM_US[jam_duration] * CYC_PER_US);
		if (!speed_100) begin
			load = JAM_CNT_W'(JAM_US[jam_duration] * CYC_PER_US + EXTRA_10M_CYC);
		end
		st_next = st_reg;
		if (abort) begin
			st_next.busy = 1'b0;
			st_next.cnt = '0;
		end else if (start) begin
			st_next.busy = 1'b1;
			st_next.cnt = load;
		end else if (st_reg.busy) begin
			if (st_reg.cnt <= JAM_CNT_W'(1)) begin
				st_next.busy = 1'b0;
				st_next.cnt = '0;
			end else begin
				st_next.cnt = st_reg.cnt - JAM_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy = st_reg.busy;

	chk_jam_load: assert property (@(posedge pclk) disable iff (!presetn)
		start && !abort |=> busy && st_reg.cnt == $past(load))
		else $error("jam timer did not load the duration");
	chk_jam_end: assert property (@(posedge pclk) disable iff (!presetn)
		busy && st_reg.cnt == JAM_CNT_W'(1) && !start && !abort |=> !busy)
		else $error("jam did not end at the programmed time");

endmodule // rffc_jam_timer

// *** tb/rffc_mac_model.sv ***
// Model of the MAC transmit path that sends the pause frames the block requests.
`timescale 1ns/1ps
module rffc_mac_model import rffc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] delay,
	input wire logic pause_req,
	input wire logic [QUANTA_W-1:0] pause_time,
	output logic pause_sent,
	output logic [QUANTA_W-1:0] last_time,
	output logic [7:0] frames,
	output logic paused
);
	logic [3:0] cnt;
	// A zero pause time lets the remote station send again at once.
	assign paused = (frames != 8'h00) && (last_time != 16'h0000);
	// The delay input lets the bench make the transmit window prompt or slow.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			pause_sent <= 1'b0;
			last_time <= 16'h0000;
			frames <= 8'h00;
		end else if (pause_sent || !pause_req) begin
			cnt <= 4'h0;
			pause_sent <= 1'b0;
		end else if (cnt >= delay) begin
			pause_sent <= 1'b1;
			last_time <= pause_time;
			frames <= frames + 8'h01;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule // rffc_mac_model

// *** tb/rx_fifo_flow_control_tb.sv ***
// Self-checking bench for the receive flow controller.
`timescale 1ns/1ps
module rx_fifo_flow_control_tb import rffc_pkg::*;;
	typedef struct packed {
		logic [3:0] bits;
		logic [3:0] dur;
		logic spd;
		logic fd;
		logic tx;
		logic [3:0] evt;
		logic at_hi;
		logic hit;
	} rffc_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b1;
	rffc_apb_req_t apb_req = '0;
	rffc_apb_rsp_t apb_rsp;
	logic tx_enabled = 1'b1;
	logic full_duplex = 1'b0;
	logic speed_100 = 1'b1;
	logic [LEVEL_W-1:0] rx_fifo_level = '0;
	rffc_rx_evt_t rx_evt = '0;
	logic [QUANTA_W-1:0] quanta = 16'h1234;
	logic [3:0] delay = 4'h0;
	logic pause_sent, pause_req, back_pressure, paused;
	logic [QUANTA_W-1:0] pause_time, last_time;
	logic [7:0] frames;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int num_checks = 0;
	int n;
	rffc_row_t r;
	// Event codes: 8 is a preamble, 6 a group address, 5 our own address.
	rffc_row_t rows [8] = '{
		'{4'h1, 4'h0, 1'h1, 1'h0, 1'h1, 4'h8, 1'h1, 1'h1},
		'{4'h8, 4'h1, 1'h0, 1'h0, 1'h1, 4'h6, 1'h1, 1'h1},
		'{4'h2, 4'hF, 1'h1, 1'h0, 1'h1, 4'h5, 1'h1, 1'h1},
		'{4'h8, 4'h3, 1'h1, 1'h0, 1'h1, 4'h5, 1'h1, 1'h0},
		'{4'h2, 4'h3, 1'h1, 1'h0, 1'h1, 4'h6, 1'h1, 1'h0},
		'{4'hA, 4'h3, 1'h1, 1'h1, 1'h1, 4'h6, 1'h1, 1'h0},
		'{4'h1, 4'h3, 1'h1, 1'h0, 1'h0, 4'h8, 1'h1, 1'h0},
		'{4'h1, 4'h3, 1'h1, 1'h0, 1'h1, 4'h8, 1'h0, 1'h0}};

	rffc_top #(.CYC_PER_US(2), .EXTRA_10M_CYC(4)) dut (
		.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.tx_enabled(tx_enabled), .full_duplex(full_duplex), .speed_100(speed_100),
		.rx_fifo_level(rx_fifo_level), .rx_evt(rx_evt), .pause_quanta_setting(quanta),
		.pause_sent(pause_sent), .pause_req(pause_req), .pause_time(pause_time),
		.back_pressure(back_pressure));

	rffc_mac_model partner (
		.pclk(pclk), .presetn(presetn), .delay(delay), .pause_req(pause_req),
		.pause_time(pause_time), .pause_sent(pause_sent), .last_time(last_time),
		.frames(frames), .paused(paused));

	always #2.5 pclk = ~pclk;

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask

	// Called just after an edge; values read after an edge are those sampled at it.
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int k;
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (apb_rsp.pready === 1'b1) begin
				break;
			end
		end
		if (k == 20) begin
			num_errors++;
		end
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge pclk);
	endtask

	task automatic cfg(input logic [3:0] dur, input logic [3:0] bits);
		apb(1'b1, FLOW_CFG_OFF, {8'h00, 8'h04, 8'h02, dur, bits});
	endtask

	initial begin
		#200_000;
		num_errors++;
		print_verdict();
	end

	initial begin
		// A real falling edge is needed, or the asynchronous reset never fires.
		presetn <= 1'b0;
		cyc(10);
		chk("reset_out", {apb_rsp.pready, apb_rsp.pslverr, pause_req, back_pressure}, 32'h0000_0000);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, FLOW_CFG_OFF, WORD_ZERO);
		chk("cfg_reset", rd, 32'h0000_0000);
		foreach (rows[i]) begin
			r = rows[i];
			cfg(r.dur, r.bits);
			full_duplex <= r.fd;
			speed_100 <= r.spd;
			tx_enabled <= r.tx;
			rx_fifo_level <= r.at_hi ? 14'h0100 : 14'h00FF;
			@(posedge pclk);
			rx_evt <= r.evt;
			@(posedge pclk);
			rx_evt <= '0;
			n = 0;
			repeat (1300) begin
				@(posedge pclk);
				n += (back_pressure === 1'b1);
			end
			chk("jam_cycles", n, r.hit ? JAM_US[r.dur] * 2 + (r.spd ? 0 : 4) : 0);
		end
		apb(1'b1, FLOW_CFG_OFF, 32'hFFFF_FEFF);
		apb(1'b0, FLOW_CFG_OFF, WORD_ZERO);
		chk("cfg_rw", rd, 32'h00FF_FEFB);
		apb(1'b0, 12'h0B0, WORD_ZERO);
		chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
		// A mid-run reset also clears the pause state before the duplex change.
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		full_duplex <= 1'b1;
		rx_fifo_level <= '0;
		delay <= 4'h9;
		@(posedge pclk);
		cfg(4'h0, 4'h1);
		cyc(20);
		chk("early_pause", frames, 32'h0000_0000);
		tx_enabled <= 1'b0;
		rx_fifo_level <= 14'h0100;
		cyc(20);
		chk("tx_off_pause", frames, 32'h0000_0000);
		tx_enabled <= 1'b1;
		cyc(40);
		chk("high_pause", {frames, last_time}, 32'h0001_1234);
		chk("partner_paused", paused, 32'h0000_0001);
		apb(1'b0, FLOW_STATUS_OFF, WORD_ZERO);
		chk("status_armed", {rd[30:0], err}, 32'h0000_0006);
		cfg(4'h0, 4'h8);
		rx_fifo_level <= 14'h0080;
		cyc(40);
		chk("at_low_level", frames, 32'h0000_0001);
		rx_fifo_level <= 14'h007F;
		cyc(40);
		chk("zero_pause", {frames, last_time}, 32'h0002_0000);
		chk("partner_resumed", paused, 32'h0000_0000);
		apb(1'b0, FLOW_STATUS_OFF, WORD_ZERO);
		chk("status_idle", {rd[30:0], err}, 32'h0000_0000);
		cfg(4'h0, 4'h1);
		delay <= 4'h0;
		rx_fifo_level <= 14'h0100;
		cyc(40);
		chk("rearm", {frames, last_time}, 32'h0003_1234);
		print_verdict();
	end
endmodule // rx_fifo_flow_control_tb
